// ===== ptt_pkg.sv
package ptt_pkg;

  // ==========================================================
  // Counter geometry
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_CURRENT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_MASK = 12'h010;
  localparam logic [11:0] OFS_ACK = 12'h014;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_IEN_BIT = 1;
  localparam int unsigned STAT_ROLL_BIT = 0;
  localparam logic [CNT_W-1:0] PERIOD_RST = 24'hffffff;
  localparam logic MASK_RST = 1'b0;

endpackage

// ===== ptt_counter.sv
`timescale 1ns/1ps

module ptt_counter
  import ptt_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic             force_clear,
  input  wire logic [CNT_W-1:0] period_m1,
  output logic      [CNT_W-1:0] count,
  output logic                  rollover
);

  // ==========================================================
  // Down counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= CNT_ZERO;
      rollover <= 1'b0;
    end else begin
      rollover <= 1'b0;
      if (force_clear) begin
        count <= CNT_ZERO;
      end else if (run) begin
        if (count == CNT_ZERO) begin
          count    <= period_m1;
          rollover <= 1'b1;
        end else begin
          count <= count - CNT_ONE;
        end
      end
    end
  end

endmodule

// ===== ptt_timer.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

module ptt_timer
  import ptt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        handler_entry,
  output logic             irq
);

  // ==========================================================
  // Bus decode
  logic             wr_en;
  logic             rd_en;
  logic             run;
  logic             int_en;
  logic [CNT_W-1:0] period_m1;
  logic [CNT_W-1:0] count;
  logic             rollover;
  logic             pending;
  logic             mask;
  logic             addr_ok;
  logic [31:0]      next_rdata;

  // Single-cycle access phase: pready is a registered one in the access cycle
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      OFS_CTRL, OFS_PERIOD, OFS_CURRENT, OFS_STATUS, OFS_MASK, OFS_ACK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // ==========================================================
  // Control and period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run    <= 1'b0;
      int_en <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL && pstrb[0]) begin
      run    <= pwdata[CTRL_RUN_BIT];
      int_en <= pwdata[CTRL_IEN_BIT];
    end
  end

  // Stored as period minus one so 16777216 fits in 24 bits; written value 0 means 2^24
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_m1 <= PERIOD_RST;
    end else if (wr_en && paddr == OFS_PERIOD && pstrb[2:0] == 3'h7) begin
      period_m1 <= pwdata[CNT_W-1:0] - CNT_ONE;
    end
  end

  // ==========================================================
  // Counter
  // wrap every period
  ptt_counter u_counter (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (run),
    .force_clear (wr_en && paddr == OFS_CURRENT),
    .period_m1   (period_m1),
    .count       (count),
    .rollover    (rollover)
  );

  // ==========================================================
  // Interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    // rollover sets flag while int_en is high; set wins over clear
    end else if (rollover && int_en) begin
      pending <= 1'b1;
    end else if (handler_entry) begin
      pending <= 1'b0;
    end else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_ROLL_BIT]) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RST;
    end else if (wr_en && paddr == OFS_MASK && pstrb[0]) begin
      mask <= pwdata[STAT_ROLL_BIT];
    end
  end

  // Level output, one cycle behind the flag, gated by mask and int_en; disable drops irq and stops further sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= pending && mask && int_en;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    next_rdata = 32'h00000000;
    case (paddr)
      OFS_CTRL: begin
        next_rdata[CTRL_RUN_BIT] = run;
        next_rdata[CTRL_IEN_BIT] = int_en;
      end
      OFS_PERIOD: next_rdata = {8'h00, period_m1} + 32'h00000001;
      OFS_CURRENT: next_rdata = {8'h00, count};
      OFS_STATUS: next_rdata[STAT_ROLL_BIT] = pending;
      OFS_MASK: next_rdata[STAT_ROLL_BIT] = mask;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule

// ===== ptt_timer_monitor.sv
`timescale 1ns/1ps
// ====
// Bus and interrupt checks
module ptt_timer_monitor
  import ptt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        handler_entry,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  unmapped_err_a: assert property (psel && !penable && paddr >= 12'h018 |=> pslverr)
    else $error("no error");
  unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("data");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("moved");
  handler_clear_a: assert property (handler_entry |-> ##[1:3] !irq) else $error("irq kept");
endmodule

bind ptt_timer ptt_timer_monitor ptt_timer_monitor_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .handler_entry(handler_entry), .irq(irq));

// ===== periodic_tick_timer_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module periodic_tick_timer_bench;
  import ptt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, handler_entry, pready, pslverr, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, a;
  int          err_count, total_checks, n;
  localparam logic [31:0] P = 32'h00000028;
  ptt_timer ptt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .handler_entry(handler_entry), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ====
  // One APB transfer, held until pready is sampled
  task automatic xf(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 16);
    if (pready !== 1'b1) err_count++;
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pulses the handler input, then counts clocks to the next sampled irq
  task automatic gap();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      handler_entry <= (n == 1);
    end while ((irq !== 1'b1 || n < 6) && n < 200);
  endtask
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, handler_entry} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xf(1'b0, OFS_PERIOD, 32'h0); `CHK("period", 32'h01000000, rv)
    xf(1'b0, OFS_CTRL, 32'h0); `CHK("ctrl", 32'h0, rv)
    xf(1'b0, OFS_MASK, 32'h0); `CHK("mask", 32'h0, rv)
    xf(1'b0, 12'h020, 32'h0); `CHK("unmapped", 1'b1, last_err)
    xf(1'b1, OFS_CTRL, 32'h1);
    xf(1'b0, OFS_CURRENT, 32'h0);
    a = rv;
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("step", a - 32'h3, rv)
    xf(1'b1, OFS_PERIOD, P);
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("undisturbed", a - 32'h9, rv)
    xf(1'b1, OFS_CURRENT, 32'h5a5a5a5a);
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("reload", 1'b1, rv < P)
    xf(1'b1, OFS_MASK, 32'h1);
    repeat (100) @(posedge pclk);
    xf(1'b0, OFS_STATUS, 32'h0); `CHK("no ien", 1'b0, rv[0])
    xf(1'b1, OFS_CTRL, 32'h3);
    gap();
    gap(); `CHK("spacing", P, 32'(n))
    xf(1'b1, OFS_CTRL, 32'h2);
    gap(); `CHK("halted irq", 1'b0, irq)
    xf(1'b0, OFS_CURRENT, 32'h0);
    a = rv;
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("held", a, rv)
    xf(1'b1, OFS_CURRENT, 32'hffffffff);
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("clear", 32'h0, rv)
    xf(1'b1, OFS_CTRL, 32'h3);
    xf(1'b0, OFS_CURRENT, 32'h0); `CHK("resume", 1'b1, rv == P - 1 || rv == P - 2)
    xf(1'b1, OFS_MASK, 32'h0);
    repeat (100) @(posedge pclk); `CHK("masked", 1'b0, irq)
    xf(1'b0, OFS_STATUS, 32'h0); `CHK("pending", 1'b1, rv[0])
    xf(1'b1, OFS_MASK, 32'h1);
    xf(1'b1, OFS_CTRL, 32'h2); `CHK("unmasked", 1'b1, irq)
    xf(1'b1, OFS_STATUS, 32'h1);
    xf(1'b0, OFS_STATUS, 32'h0); `CHK("cleared", 1'b0, irq | rv[0])
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule
